// *** wave_out_regs.svh ***
// Constants of the waveform output routing and modulation stage
`ifndef WAVE_OUT_REGS_SVH
`define WAVE_OUT_REGS_SVH

`define CLK_PERIOD_PS 10000
`define FAST_LIMIT_NS 150
`define FAST_LIMIT_CYC ((`FAST_LIMIT_NS * 1000) / `CLK_PERIOD_PS)
`define SLOW_LIMIT_US 100
`define SLOW_LIMIT_CYC ((`SLOW_LIMIT_US * 1000000) / `CLK_PERIOD_PS)
`define SLOW_DELAY_CYC 1000
`define FREQ_MAX_HZ 600000000
`define PHASE_MAX 24'h800000
`define SCOPE_TRIG_GEN1 8'hC0
`define AM_CARRIER_GEN1 3'h3
`define AM_CARRIER_GEN2 3'h7
`define OSC_SEL_RESET 3'h0
`define PHASE_RESET 24'h000000
`define FREQ_RESET 32'h00000000
`define LEADER_INDEX 4'h0

`endif

// *** wave_out_pkg.sv ***
// Types of the waveform output routing and modulation stage
package wave_out_pkg;
	typedef enum logic [1:0] {mod_plain, mod_am, mod_advanced} mod_mode_t;
	typedef enum logic [1:0] {set_freq, set_phase, set_oscsel, set_slow}
		setting_kind_t;
endpackage

// *** skid_buffer.sv ***
// Two-entry valid/ready buffer for sample pairs
`timescale 1ns/10ps
`default_nettype none
module skid_buffer #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] store [2];
	logic rd_ptr;
	logic wr_ptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = store[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			store[0] <= '0;
			store[1] <= '0;
		end
		else if (push)
			store[wr_ptr] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// *** wave_out.sv ***
// Waveform output routing, carrier modulation and fast setting writes
`timescale 1ns/10ps
`default_nettype none
`include "wave_out_regs.svh"
module wave_out #(
	parameter int WIDTH = 16,
	parameter int NUM_DEMODS = 8,
	parameter int SLOW_DELAY = `SLOW_DELAY_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Play command and envelope samples
	input wire logic play_valid,
	output logic play_ready,
	input wire logic [1:0] gen1_route,
	input wire logic [1:0] gen2_route,
	input wire logic gen2_used,
	input wire logic signed [WIDTH-1:0] gen1_sample,
	input wire logic signed [WIDTH-1:0] gen2_sample,
	input wire logic play_last,
	output logic play_done,
	// Per generator output settings
	input wire wave_out_pkg::mod_mode_t gen1_mode,
	input wire wave_out_pkg::mod_mode_t gen2_mode,
	input wire logic [WIDTH-1:0] gen1_full_scale_amplitude,
	input wire logic [WIDTH-1:0] gen2_full_scale_amplitude,
	// Carriers from the oscillators, one per oscillator
	input wire logic signed [8*WIDTH-1:0] osc_carrier,
	// Setting writes
	input wire logic set_valid,
	output logic set_ready,
	input wire logic set_is_float,
	input wire logic [3:0] set_device,
	input wire wave_out_pkg::setting_kind_t set_kind,
	input wire logic [2:0] set_index,
	input wire logic [31:0] set_value,
	input wire logic [3:0] own_device,
	input wire logic [7:0] slow_path,
	// Applied fast and slow settings
	output logic [8*32-1:0] osc_freq,
	output logic [8*24-1:0] demod_phase,
	output logic [8*3-1:0] demod_osc_sel,
	output logic set_error,
	output logic slow_apply,
	output logic [7:0] slow_path_out,
	output logic [31:0] slow_value_out,
	output logic scope_trig_gen1,
	// Signal outputs
	output logic out_valid,
	input wire logic out_ready,
	output logic signed [WIDTH-1:0] sig_out1,
	output logic signed [WIDTH-1:0] sig_out2
);
	// ---------------------------------------------------------------
	// Modulation of each generator output
	// ---------------------------------------------------------------
	logic [1:0] slot;
	logic busy;
	logic signed [WIDTH-1:0] env1;
	logic signed [WIDTH-1:0] env2;
	logic [1:0] route1;
	logic [1:0] route2;
	logic use2;
	logic last_held;
	logic signed [WIDTH-1:0] mod1;
	logic signed [WIDTH-1:0] mod2;
	logic signed [WIDTH-1:0] out1_sum;
	logic signed [WIDTH-1:0] out2_sum;
	logic buf_ready;
	logic stage_valid;

	function automatic logic signed [WIDTH-1:0] carrier_of(
		input logic [8*WIDTH-1:0] bus, input logic [2:0] idx);
		carrier_of = bus[idx*WIDTH +: WIDTH];
	endfunction

	// Full-scale gain and carrier product, Q(WIDTH-1) fractions
	function automatic logic signed [WIDTH-1:0] mult(
		input logic signed [WIDTH-1:0] a, input logic signed [WIDTH-1:0] b);
		logic signed [2*WIDTH-1:0] p;
		p = a * b;
		mult = p[2*WIDTH-2 -: WIDTH];
	endfunction

	function automatic logic signed [WIDTH-1:0] modulate(
		input logic signed [WIDTH-1:0] env,
		input wave_out_pkg::mod_mode_t mode,
		input logic [WIDTH-1:0] fs,
		input logic [2:0] am_car,
		input logic [1:0] k,
		input logic [8*WIDTH-1:0] cars,
		input logic [8*3-1:0] sel);
		logic signed [WIDTH-1:0] scaled;
		scaled = mult(env, $signed(fs));
		unique case (mode)
			wave_out_pkg::mod_plain: modulate = scaled;
			wave_out_pkg::mod_am: modulate = mult(scaled,
				carrier_of(cars, sel[am_car*3 +: 3]));
			// Envelope slot k multiplies the carrier of demod k
			wave_out_pkg::mod_advanced: modulate = mult(scaled,
				carrier_of(cars, sel[{1'b0, k}*3 +: 3]));
			default: modulate = scaled;
		endcase
	endfunction

	// Mode and scale belong to the generator, applied before routing
	assign mod1 = modulate(env1, gen1_mode, gen1_full_scale_amplitude,
		`AM_CARRIER_GEN1, slot, osc_carrier, demod_osc_sel);
	assign mod2 = use2 ? modulate(env2, gen2_mode,
		gen2_full_scale_amplitude, `AM_CARRIER_GEN2, slot, osc_carrier,
		demod_osc_sel) : '0;

	// ---------------------------------------------------------------
	// Routing to signal outputs
	// ---------------------------------------------------------------
	// Bit 0 of a route selects output 1, bit 1 output 2
	always_comb
	begin
		out1_sum = '0;
		out2_sum = '0;
		if (route1[0])
			out1_sum = out1_sum + mod1;
		if (route1[1])
			out2_sum = out2_sum + mod1;
		if (use2 && route2[0])
			out1_sum = out1_sum + mod2;
		if (use2 && route2[1])
			out2_sum = out2_sum + mod2;
	end

	// ---------------------------------------------------------------
	// Sample capture
	// ---------------------------------------------------------------
	// One sample per cycle; the buffer stalls the sequencer on back-pressure
	assign play_ready = buf_ready;
	assign stage_valid = busy;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy <= 1'b0;
			env1 <= '0;
			env2 <= '0;
			route1 <= 2'h1;
			route2 <= 2'h2;
			use2 <= 1'b0;
			last_held <= 1'b0;
		end
		else if (buf_ready)
		begin
			busy <= play_valid;
			env1 <= gen1_sample;
			env2 <= gen2_sample;
			route1 <= (gen1_route == 2'h0) ? 2'h1 : gen1_route;
			route2 <= (gen2_route == 2'h0) ? 2'h2 : gen2_route;
			use2 <= gen2_used;
			last_held <= play_valid && play_last;
		end
	end

	// Slot advances each sample, restarts after a waveform ends.
	// Each carrier sees every fourth envelope sample, so its envelope
	// runs at a quarter of the sample rate while the carrier runs at full.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			slot <= 2'h0;
		else if (busy && buf_ready)
			slot <= last_held ? 2'h0 : slot + 2'h1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			play_done <= 1'b0;
		else
			play_done <= busy && buf_ready && last_held;
	end

	skid_buffer #(.WIDTH(2*WIDTH)) skid_buffer_i (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(stage_valid),
		.in_ready(buf_ready),
		.in_data({out1_sum, out2_sum}),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data({sig_out1, sig_out2})
	);

	// ---------------------------------------------------------------
	// Setting writes
	// ---------------------------------------------------------------
	logic [$clog2(SLOW_DELAY+1)-1:0] slow_count;
	logic slow_busy;
	logic [31:0] slow_value;
	logic [7:0] slow_held_path;
	logic accept;
	logic for_me;
	logic value_ok;

	// Writes wait behind a sample still offered or captured, and a pending slow write
	// play_last is not looked at, so a write can land in a gap between samples of a waveform
	assign set_ready = !slow_busy && !busy && !play_valid;
	assign accept = set_valid && set_ready;
	assign for_me = (set_device == own_device);

	always_comb
	begin
		value_ok = 1'b1;
		unique case (set_kind)
			wave_out_pkg::set_freq: value_ok = set_is_float
				&& (set_value <= 32'(`FREQ_MAX_HZ));
			wave_out_pkg::set_phase: value_ok = !set_is_float
				&& (set_value <= {8'h00, `PHASE_MAX});
			wave_out_pkg::set_oscsel: value_ok = !set_is_float
				&& (set_value <= 32'h00000007);
			wave_out_pkg::set_slow: value_ok = 1'b1;
		endcase
	end

	// Fast writes land one cycle after acceptance, well inside the limit
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			osc_freq <= '0;
			demod_phase <= '0;
			demod_osc_sel <= '0;
			set_error <= 1'b0;
		end
		else
		begin
			set_error <= accept && for_me && !value_ok;
			if (accept && for_me && value_ok)
			begin
				unique case (set_kind)
					wave_out_pkg::set_freq:
						osc_freq[set_index*32 +: 32] <= set_value;
					wave_out_pkg::set_phase:
						demod_phase[set_index*24 +: 24] <=
							set_value[23:0];
					wave_out_pkg::set_oscsel:
						demod_osc_sel[set_index*3 +: 3] <=
							set_value[2:0];
					wave_out_pkg::set_slow: ;
				endcase
			end
		end
	end

	// Slow settings released after a fixed delay below the limit
	// Counted in clock periods; SLOW_DELAY must stay below the limit
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			slow_busy <= 1'b0;
			slow_count <= '0;
			slow_value <= '0;
			slow_held_path <= 8'h00;
			slow_apply <= 1'b0;
		end
		else
		begin
			slow_apply <= 1'b0;
			if (accept && for_me && set_kind == wave_out_pkg::set_slow)
			begin
				slow_busy <= 1'b1;
				slow_count <= '0;
				slow_value <= set_value;
				slow_held_path <= slow_path;
			end
			else if (slow_busy)
			begin
				if (slow_count == ($bits(slow_count))'(SLOW_DELAY - 1))
				begin
					slow_busy <= 1'b0;
					slow_apply <= 1'b1;
				end
				else
					slow_count <= slow_count + 1'b1;
			end
		end
	end

	assign slow_path_out = slow_held_path;
	assign slow_value_out = slow_value;

	// Scope trigger source register, picks generator trigger 1
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			scope_trig_gen1 <= 1'b0;
		else if (slow_apply && slow_held_path == 8'h00)
			scope_trig_gen1 <= (slow_value == 32'(`SCOPE_TRIG_GEN1));
	end
endmodule
`default_nettype wire

// *** wave_out_asserts.sv ***
// Port checks for the waveform output stage
`timescale 1ns/10ps
`default_nettype none
`include "wave_out_regs.svh"
module wave_out_asserts #(
	parameter int WIDTH = 16,
	parameter int SLOW_DELAY = `SLOW_DELAY_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Samples
	input wire logic play_valid,
	input wire logic play_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic signed [WIDTH-1:0] sig_out1,
	input wire logic signed [WIDTH-1:0] sig_out2,
	// Writes
	input wire logic set_valid,
	input wire logic set_ready,
	input wire logic set_is_float,
	input wire logic [3:0] set_device,
	input wire wave_out_pkg::setting_kind_t set_kind,
	input wire logic [2:0] set_index,
	input wire logic [31:0] set_value,
	input wire logic [3:0] own_device,
	input wire logic [8*32-1:0] osc_freq,
	input wire logic set_error,
	input wire logic slow_apply
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Cycles since a slow write was taken, zero when none pends
	logic [15:0] slow_cnt;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			slow_cnt <= 16'h0000;
		else if (slow_apply)
			slow_cnt <= 16'h0000;
		else if (slow_cnt != 16'h0000 || (set_valid && set_ready &&
			set_kind == wave_out_pkg::set_slow && set_device == own_device))
			slow_cnt <= slow_cnt + 16'h0001;
	end
	sequence s_take;
		set_valid && set_ready && set_device == own_device;
	endsequence
	a_out_hold: assert property (out_valid && !out_ready |=> out_valid &&
		$stable(sig_out1) && $stable(sig_out2)) else $error("output moved");
	a_play_lands: assert property (play_valid && play_ready |->
		##2 out_valid) else $error("sample lost");
	a_phase_range: assert property (s_take ##0 (set_value > 32'h00800000 &&
		set_kind == wave_out_pkg::set_phase) |=> set_error) else $error("phase");
	a_osc_range: assert property (s_take ##0 (set_value > 32'h00000007 &&
		set_kind == wave_out_pkg::set_oscsel) |=> set_error) else $error("osc");
	a_freq_apply: assert property (s_take ##0 (set_is_float &&
		set_kind == wave_out_pkg::set_freq && set_value <= 32'h23C34600)
		|=> osc_freq[$past(set_index)*32 +: 32] == $past(set_value))
		else $error("freq not applied");
	a_foreign_skip: assert property (set_valid && set_ready &&
		set_device != own_device |=> !set_error && $stable(osc_freq))
		else $error("foreign write used");
	a_slow_delay: assert property (slow_apply |->
		slow_cnt == SLOW_DELAY + 1) else $error("slow delay");
	a_write_wait: assert property (play_valid ||
		(slow_cnt != 16'h0000 && !slow_apply) |-> !set_ready)
		else $error("write not held");
endmodule
`default_nettype wire

// *** dac_model.sv ***
// Signal output converter model that can stall the stage
`timescale 1ns/10ps
`default_nettype none
module dac_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Flow control
	input wire logic stall,
	output logic out_ready
);
	// Refuses while in reset so nothing is taken before the stage is up
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			out_ready <= 1'b0;
		else
			out_ready <= !stall;
	end
endmodule
`default_nettype wire

// *** tb_wave_out.sv ***
// Self-checking bench for the waveform output stage
`timescale 1ns/10ps
`default_nettype none
module tb_wave_out;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic play_valid = 1'b0, gen2_used = 1'b0, play_last = 1'b1;
	logic play_ready, play_done, set_ready, set_error, slow_apply;
	logic scope_trig_gen1, out_valid, out_ready;
	logic stall = 1'b0, set_valid = 1'b0, set_is_float = 1'b0;
	logic [1:0] gen1_route = 2'h0, gen2_route = 2'h0;
	logic signed [15:0] gen1_sample = 16'h0000, gen2_sample = 16'h0000;
	logic signed [15:0] sig_out1, sig_out2;
	logic [15:0] gen1_full_scale_amplitude = 16'h4000;
	logic [15:0] gen2_full_scale_amplitude = 16'h6000;
	wave_out_pkg::mod_mode_t gen1_mode = wave_out_pkg::mod_plain;
	wave_out_pkg::mod_mode_t gen2_mode = wave_out_pkg::mod_plain;
	wave_out_pkg::setting_kind_t set_kind = wave_out_pkg::set_freq;
	logic [127:0] osc_carrier = 128'h0;
	logic [3:0] set_device = 4'h0, own_device = 4'h0;
	logic [2:0] set_index = 3'h0;
	logic [31:0] set_value = 32'h0, slow_value_out;
	logic [7:0] slow_path = 8'h00, slow_path_out;
	logic [255:0] osc_freq;
	logic [191:0] demod_phase;
	logic [23:0] demod_osc_sel;
	int num_errors = 0, total_checks = 0, errs = 0, dones = 0;
	logic [31:0] q[$];
	wave_out #(.WIDTH(16), .SLOW_DELAY(10)) wave_out_i (.clk, .rst_b,
		.play_valid, .play_ready, .gen1_route, .gen2_route, .gen2_used,
		.gen1_sample, .gen2_sample, .play_last, .play_done, .gen1_mode,
		.gen2_mode, .gen1_full_scale_amplitude, .gen2_full_scale_amplitude,
		.osc_carrier, .set_valid, .set_ready, .set_is_float, .set_device,
		.set_kind, .set_index, .set_value, .own_device, .slow_path,
		.osc_freq, .demod_phase, .demod_osc_sel, .set_error, .slow_apply,
		.slow_path_out, .slow_value_out, .scope_trig_gen1, .out_valid,
		.out_ready, .sig_out1, .sig_out2);
	dac_model dac_model_i (.clk, .rst_b, .stall, .out_ready);
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		if (out_valid === 1'b1 && out_ready === 1'b1)
			q.push_back({sig_out1, sig_out2});
		if (set_error === 1'b1)
			errs++;
		if (play_done === 1'b1)
			dones++;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Waits until ready is seen at a falling edge, then lets one edge take it
	task automatic await(ref logic rdy);
		int n;
		n = 0;
		@(negedge clk);
		while (rdy !== 1'b1 && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		if (rdy !== 1'b1)
		begin
			num_errors++;
			results();
		end
		else
			@(posedge clk);
	endtask
	task play(input logic [3:0] rt, input logic u, input logic [31:0] e);
		@(posedge clk);
		play_valid <= 1'b1;
		{gen1_route, gen2_route, gen2_used} <= {rt, u};
		{gen1_sample, gen2_sample} <= e;
		await(play_ready);
		play_valid <= 1'b0;
	endtask
	task pop(input logic [31:0] exp);
		int n;
		n = 0;
		while (q.size() == 0 && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		if (q.size() == 0)
		begin
			num_errors++;
			results();
		end
		else
			chk("sample", q.pop_front(), exp);
	endtask
	task wr(input wave_out_pkg::setting_kind_t k, input logic [2:0] i,
		input logic [31:0] v, input logic f, input logic [3:0] d);
		@(posedge clk);
		set_valid <= 1'b1;
		set_kind <= k;
		set_index <= i;
		set_value <= v;
		set_is_float <= f;
		set_device <= d;
		await(set_ready);
		set_valid <= 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task t_route;
		play(4'h0, 1'b1, 32'h20004000);
		pop(32'h10003000);
		play(4'h9, 1'b1, 32'h20004000);
		pop(32'h30001000);
		play(4'hC, 1'b0, 32'h20004000);
		pop(32'h10001000);
		play(4'h5, 1'b1, 32'h20004000);
		pop(32'h40000000);
		play(4'h8, 1'b0, 32'h20004000);
		pop(32'h00001000);
	endtask
	task t_stall;
		@(posedge clk);
		stall <= 1'b1;
		play_last <= 1'b0;
		gen1_full_scale_amplitude <= 16'h2000;
		play(4'h0, 1'b0, 32'h04000000);
		play(4'h0, 1'b0, 32'h08000000);
		fork
			play(4'h0, 1'b0, 32'h0C000000);
			begin
				repeat (20) @(negedge clk);
				chk("refused", {play_ready, q.size() == 0}, 32'h1);
				@(posedge clk);
				stall <= 1'b0;
				play_last <= 1'b1;
			end
		join
		pop(32'h01000000);
		pop(32'h02000000);
		pop(32'h03000000);
	endtask
	task t_fast;
		wr(wave_out_pkg::set_freq, 3'h2, 32'd35000000, 1'b1, 4'h0);
		chk("freq", osc_freq[64 +: 32], 32'd35000000);
		wr(wave_out_pkg::set_phase, 3'h3, 32'h00100000, 1'b0, 4'h0);
		wr(wave_out_pkg::set_phase, 3'h3, 32'h00800001, 1'b0, 4'h0);
		chk("phase", demod_phase[72 +: 24], 32'h00100000);
		wr(wave_out_pkg::set_phase, 3'h1, 32'h00800000, 1'b0, 4'h0);
		chk("phase max", demod_phase[24 +: 24], 32'h00800000);
		wr(wave_out_pkg::set_oscsel, 3'h3, 32'h7, 1'b0, 4'h0);
		wr(wave_out_pkg::set_oscsel, 3'h3, 32'h8, 1'b0, 4'h0);
		chk("osc sel", demod_osc_sel[9 +: 3], 32'h7);
		wr(wave_out_pkg::set_freq, 3'h0, 32'd600000001, 1'b1, 4'h0);
		wr(wave_out_pkg::set_freq, 3'h2, 32'h1, 1'b1, 4'h1);
		chk("foreign", osc_freq[64 +: 32], 32'd35000000);
		chk("errors", errs, 32'h3);
	endtask
	task t_slow(input logic [31:0] v, input logic [7:0] p, input logic exp);
		@(posedge clk);
		slow_path <= p;
		wr(wave_out_pkg::set_slow, 3'h0, v, 1'b0, 4'h0);
		await(slow_apply);
		@(negedge clk);
		chk("scope trig", scope_trig_gen1, exp);
		chk("slow value", slow_value_out, v);
		chk("slow path", slow_path_out, p);
	endtask
	task t_multi;
		for (int j = 0; j < 4; j++)
		begin
			wr(wave_out_pkg::set_oscsel, 3'(j), 32'(j), 1'b0, 4'h0);
			wr(wave_out_pkg::set_freq, 3'(j), 32'((j + 1) * 5000000), 1'b1,
				4'h0);
		end
		wr(wave_out_pkg::set_oscsel, 3'h7, 32'h5, 1'b0, 4'h0);
		chk("freq 4", osc_freq[96 +: 32], 32'd20000000);
		chk("osc sel 8", demod_osc_sel[21 +: 3], 32'h5);
		@(posedge clk);
		osc_carrier <= 128'h0800_7000_6000_5000_4000_3000_2000_1000;
		gen1_full_scale_amplitude <= 16'h4000;
		gen1_mode <= wave_out_pkg::mod_advanced;
		for (int j = 0; j < 4; j++)
		begin
			play_last <= (j == 3);
			play(4'h0, 1'b0, 32'h40000000);
		end
		pop(32'h04000000);
		pop(32'h08000000);
		pop(32'h0C000000);
		pop(32'h10000000);
		@(posedge clk);
		gen1_mode <= wave_out_pkg::mod_am;
		gen2_mode <= wave_out_pkg::mod_am;
		play(4'h0, 1'b1, 32'h40004000);
		pop(32'h10002400);
		chk("done pulses", dones, 32'h8);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_route();
		t_stall();
		t_fast();
		t_slow(32'd192, 8'h00, 1'b1);
		t_slow(32'h5, 8'h21, 1'b1);
		t_slow(32'h5, 8'h00, 1'b0);
		t_multi();
		results();
	end
endmodule
bind wave_out wave_out_asserts #(.WIDTH(WIDTH), .SLOW_DELAY(SLOW_DELAY))
	wave_out_asserts_i (.clk, .rst_b, .play_valid, .play_ready, .out_valid,
	.out_ready, .sig_out1, .sig_out2, .set_valid, .set_ready, .set_is_float,
	.set_device, .set_kind, .set_index, .set_value, .own_device, .osc_freq,
	.set_error, .slow_apply);
`default_nettype wire
